// ---- inc/acc_pkg.sv ----
// Summary of operation
// R01 - bit 10 enables channel two, resets 1
// R02 - bit 9 enables channel one, resets 1
// R03 - bit 8 enables channel zero, resets 1
// R04 - host writes zeros to reserved bits 7:6
// R05 - turbo bit 5 forces ratio 64, resets 0
// R06 - turbo clear: ratio from bits 4:2
// R07 - field code 000 is 128, doubling, reset 011
// R08 - field code 111 decodes as 16384
`default_nettype none
package acc_pkg;
    // bus geometry
    localparam int ACC_DATA_W = 32; // apb data width
    localparam int ACC_ADDR_W = 12; // apb byte address width
    localparam int ACC_REG_W = 16; // width of the configuration register
    // register indices; byte address is four times the index
    localparam int ACC_CFG_IDX = 3; // converter_clock_config index
    localparam int ACC_STAT_IDX = 8; // ratio status index
    localparam logic [ACC_ADDR_W-1:0] ACC_CFG_ADDR = 12'(ACC_CFG_IDX * 4); // byte address of config
    localparam logic [ACC_ADDR_W-1:0] ACC_STAT_ADDR = 12'(ACC_STAT_IDX * 4); // byte address of status
    // configuration field layout
    localparam int ACC_NUM_CHAN = 3; // channels held here
    localparam int ACC_CH0_BIT = 8; // channel zero enable position
    localparam int ACC_RSV_LSB = 6; // reserved pair low bit
    localparam int ACC_RSV_W = 2; // reserved pair width
    localparam int ACC_TURBO_BIT = 5; // turbo ratio select position
    localparam int ACC_RATIO_LSB = 2; // ratio field low bit
    localparam int ACC_RATIO_W = 3; // ratio field width
    // byte lanes of pstrb
    localparam int ACC_LANE_LO = 0; // covers bits 7:0
    localparam int ACC_LANE_HI = 1; // covers bits 15:8
    localparam int ACC_LANE_ST = 2; // covers bits 23:16
    // reset values
    localparam logic ACC_CH_EN_RST = 1'h1; // channels start enabled
    localparam logic ACC_TURBO_RST = 1'h0; // turbo starts off
    localparam logic [ACC_RATIO_W-1:0] ACC_RATIO_RST = 3'h3; // code for 1024
    localparam logic [ACC_RSV_W-1:0] ACC_RSV_RST = 2'h0; // reserved pair reset
    // oversampling ratio values
    localparam int ACC_OSR_W = 15; // wide enough for 16384
    localparam logic [ACC_OSR_W-1:0] ACC_OSR_TURBO = 15'h0040; // 64
    localparam logic [ACC_OSR_W-1:0] ACC_OSR_BASE = 15'h0080; // 128 at code 000
    localparam logic [ACC_OSR_W-1:0] ACC_OSR_RST = 15'h0400; // 1024
    localparam logic [ACC_OSR_W-1:0] ACC_OSR_8192 = 15'h2000; // code 110
    localparam logic [ACC_OSR_W-1:0] ACC_OSR_16384 = 15'h4000; // code 111
    localparam logic [ACC_RATIO_W-1:0] ACC_CODE_MIN = 3'h0; // lowest code
    localparam logic [ACC_RATIO_W-1:0] ACC_CODE_6 = 3'h6; // 8192 code
    localparam logic [ACC_RATIO_W-1:0] ACC_CODE_MAX = 3'h7; // highest code
    // status field layout
    localparam int ACC_STAT_OSR_LSB = 0; // effective ratio low bit
    localparam int ACC_STAT_TURBO_BIT = 15; // turbo active
    localparam int ACC_STAT_RSVW_BIT = 16; // reserved-bit write seen, write one to clear
    // apb response phase
    typedef enum logic {
        ACC_IDLE,
        ACC_ACCESS
    } acc_phase_t;
endpackage
`default_nettype wire

// ---- logic/acc_osr_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_osr_config
    import acc_pkg::*;
(
    input wire logic clk_sys, // system clock, 40 MHz
    input wire logic rst, // async reset, active high
    input wire logic [ACC_ADDR_W-1:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction, high for write
    input wire logic [ACC_DATA_W-1:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [ACC_DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error for unmapped address
    output logic chan_zero_enable, // channel zero converter enable
    output logic chan_one_enable, // channel one converter enable
    output logic chan_two_enable, // channel two converter enable
    output logic turbo_ratio_select, // turbo ratio selected
    output logic [ACC_RATIO_W-1:0] oversampling_ratio_field, // raw ratio field
    output logic [ACC_OSR_W-1:0] osr_value, // effective oversampling ratio
    output logic osr_update // pulse when the effective ratio changes
);
    // ---- bus phase tracking ----
    acc_phase_t phase_ff; // response phase
    acc_phase_t nxt_phase; // next response phase
    logic pready_ff; // ready towards the master
    logic nxt_pready; // next ready
    logic pslverr_ff; // error flag of the current answer
    logic nxt_pslverr; // next error flag
    logic [ACC_DATA_W-1:0] prdata_ff; // read data of the current answer
    logic [ACC_DATA_W-1:0] nxt_prdata; // next read data

    // ---- configuration state ----
    logic [ACC_NUM_CHAN-1:0] chan_en_ff; // per-channel enables
    logic [ACC_NUM_CHAN-1:0] nxt_chan_en; // next per-channel enables
    logic [ACC_RSV_W-1:0] rsv_ff; // reserved pair, stored as written
    logic [ACC_RSV_W-1:0] nxt_rsv; // next reserved pair
    logic turbo_ff; // turbo ratio select
    logic nxt_turbo; // next turbo ratio select
    logic [ACC_RATIO_W-1:0] field_ff; // ratio field
    logic [ACC_RATIO_W-1:0] nxt_field; // next ratio field
    logic rsvw_ff; // sticky: host put ones into the reserved pair
    logic nxt_rsvw; // next sticky flag

    // ---- decoded bus terms ----
    logic setup_cyc; // first cycle of a transfer
    logic done_cyc; // edge at which the transfer completes
    logic hit_cfg; // address selects the configuration word
    logic hit_stat; // address selects the status word
    logic wr_cfg_lo; // config write, low byte lane
    logic wr_cfg_hi; // config write, high byte lane
    logic wr_stat_clr; // status write of one to the sticky bit
    logic [ACC_OSR_W-1:0] osr_w; // decoder ratio output
    logic osr_upd_w; // decoder change pulse

    // address and strobe decode; only the completing edge may write
    always_comb begin
        setup_cyc = psel && !penable;
        done_cyc = psel && penable && pready_ff;
        hit_cfg = (paddr == ACC_CFG_ADDR);
        hit_stat = (paddr == ACC_STAT_ADDR);
        wr_cfg_lo = done_cyc && pwrite && hit_cfg && pstrb[ACC_LANE_LO];
        wr_cfg_hi = done_cyc && pwrite && hit_cfg && pstrb[ACC_LANE_HI];
        wr_stat_clr = done_cyc && pwrite && hit_stat && pstrb[ACC_LANE_ST] && pwdata[ACC_STAT_RSVW_BIT];
    end

    // answer one cycle after setup: the access phase never waits
    always_comb begin
        nxt_phase = phase_ff;
        nxt_pready = 1'h0;
        case (phase_ff)
            ACC_IDLE: begin
                if (setup_cyc) begin
                    nxt_phase = ACC_ACCESS; // answer is ready in the access phase
                    nxt_pready = 1'h1;
                end
            end
            ACC_ACCESS: begin
                // the access completes here; a new setup can only come next cycle
                nxt_phase = ACC_IDLE;
            end
            default: begin
                nxt_phase = ACC_IDLE; // recover from an illegal code
            end
        endcase
    end

    // read data and error are formed in setup and held through access
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup_cyc) begin
            nxt_prdata = '0;
            nxt_pslverr = !(hit_cfg || hit_stat); // unmapped: error, reads zero
            if (!pwrite && hit_cfg) begin
                // bits 15:12, 11 and 1:0 are not held here and read zero
                nxt_prdata[ACC_CH0_BIT +: ACC_NUM_CHAN] = chan_en_ff;
                nxt_prdata[ACC_RSV_LSB +: ACC_RSV_W] = rsv_ff;
                nxt_prdata[ACC_TURBO_BIT] = turbo_ff;
                nxt_prdata[ACC_RATIO_LSB +: ACC_RATIO_W] = field_ff;
            end else if (!pwrite && hit_stat) begin
                nxt_prdata[ACC_STAT_OSR_LSB +: ACC_OSR_W] = osr_w;
                nxt_prdata[ACC_STAT_TURBO_BIT] = turbo_ff;
                nxt_prdata[ACC_STAT_RSVW_BIT] = rsvw_ff;
            end
        end else if (done_cyc) begin
            nxt_pslverr = 1'h0; // error must not linger past its access
        end
    end

    // bus response registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_ff <= ACC_IDLE;
            pready_ff <= 1'h0;
            pslverr_ff <= 1'h0;
            prdata_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // per-channel enables, one slice per converter
    genvar gi;
    generate
        for (gi = 0; gi < ACC_NUM_CHAN; gi++) begin : g_chan
            // a channel that is off keeps its modulator idle
            always_comb begin
                nxt_chan_en[gi] = chan_en_ff[gi];
                if (wr_cfg_hi) begin
                    nxt_chan_en[gi] = pwdata[ACC_CH0_BIT + gi]; // R01 R02 R03
                end
            end

            // enables come up on so all converters run after reset
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    chan_en_ff[gi] <= ACC_CH_EN_RST; // R01 R02 R03
                end else begin
                    chan_en_ff[gi] <= nxt_chan_en[gi];
                end
            end
        end
    endgenerate

    // low byte: reserved pair, turbo and ratio field
    always_comb begin
        nxt_rsv = rsv_ff;
        nxt_turbo = turbo_ff;
        nxt_field = field_ff;
        if (wr_cfg_lo) begin
            nxt_rsv = pwdata[ACC_RSV_LSB +: ACC_RSV_W];
            nxt_turbo = pwdata[ACC_TURBO_BIT]; // R05
            nxt_field = pwdata[ACC_RATIO_LSB +: ACC_RATIO_W]; // R06
        end
    end

    // sticky flag for ones written to the reserved pair; set wins over clear
    always_comb begin
        nxt_rsvw = rsvw_ff;
        if (wr_stat_clr) begin
            nxt_rsvw = 1'h0;
        end
        if (wr_cfg_lo && (pwdata[ACC_RSV_LSB +: ACC_RSV_W] != ACC_RSV_RST)) begin
            nxt_rsvw = 1'h1; // R04
        end
    end

    // configuration low byte registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsv_ff <= ACC_RSV_RST;
            turbo_ff <= ACC_TURBO_RST; // R05
            field_ff <= ACC_RATIO_RST; // R07
            rsvw_ff <= 1'h0;
        end else begin
            rsv_ff <= nxt_rsv;
            turbo_ff <= nxt_turbo;
            field_ff <= nxt_field;
            rsvw_ff <= nxt_rsvw;
        end
    end

    // ratio decode is registered; the change pulse lets decimators restart cleanly
    acc_ratio_decode acc_ratio_decode_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .turbo(turbo_ff),
        .field(field_ff),
        .ratio(osr_w),
        .update(osr_upd_w)
    );

    // every output is a flip-flop, either here or in the decoder
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign chan_zero_enable = chan_en_ff[0];
    assign chan_one_enable = chan_en_ff[1];
    assign chan_two_enable = chan_en_ff[2];
    assign turbo_ratio_select = turbo_ff;
    assign oversampling_ratio_field = field_ff;
    assign osr_value = osr_w;
    assign osr_update = osr_upd_w;

    // ---- checks ----
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // completing write to the configuration word, per byte lane
    sequence s_cfg_wr_hi;
        psel && penable && pready_ff && pwrite && (paddr == ACC_CFG_ADDR) && pstrb[ACC_LANE_HI];
    endsequence

    sequence s_cfg_wr_lo;
        psel && penable && pready_ff && pwrite && (paddr == ACC_CFG_ADDR) && pstrb[ACC_LANE_LO];
    endsequence

    a_chan_two_wr: assert property (s_cfg_wr_hi |=> chan_two_enable == $past(pwdata[ACC_CH0_BIT + 2])) // R01
        else $error("channel two enable did not take written bit");
    a_chan_one_wr: assert property (s_cfg_wr_hi |=> chan_one_enable == $past(pwdata[ACC_CH0_BIT + 1])) // R02
        else $error("channel one enable did not take written bit");
    a_chan_zero_hold: assert property (!wr_cfg_hi |=> $stable(chan_zero_enable)) // R03
        else $error("channel zero enable changed without a write");
    a_rsv_flag_set: assert property (s_cfg_wr_lo ##0 (pwdata[ACC_RSV_LSB +: ACC_RSV_W] != ACC_RSV_RST) |=> rsvw_ff) // R04
        else $error("reserved-bit write not flagged");
    a_turbo_ratio: assert property (s_cfg_wr_lo ##0 pwdata[ACC_TURBO_BIT] |=> ##1 osr_value == ACC_OSR_TURBO) // R05
        else $error("turbo did not force ratio 64");
    a_field_ratio: assert property (!turbo_ff |=> osr_value == ACC_OSR_W'(ACC_OSR_BASE << $past(field_ff))) // R06
        else $error("ratio does not follow field while turbo is clear");
    a_code_ends: assert property (!turbo_ff && field_ff == ACC_CODE_MIN |=> osr_value == ACC_OSR_BASE) // R07
        else $error("code 000 is not 128");
    a_code_8192: assert property (!turbo_ff && field_ff == ACC_CODE_6 |=> osr_value == ACC_OSR_8192) // R07
        else $error("code 110 is not 8192");
    a_code_top: assert property (!turbo_ff && field_ff == ACC_CODE_MAX |=> osr_value == ACC_OSR_16384) // R08
        else $error("code 111 is not 16384");
    a_bus_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("answer not given in the single access cycle");

    // channel zero takes its written bit like the other two
    a_chan_zero_wr: assert property (s_cfg_wr_hi |=> chan_zero_enable == $past(pwdata[ACC_CH0_BIT])) // R03
        else $error("channel zero enable did not take written bit");
    // without the high lane, channels one and two must stay as they are
    a_chan_hi_hold: assert property (!wr_cfg_hi |=> $stable({chan_two_enable, chan_one_enable})) // R01 R02
        else $error("channel one or two enable changed without a write");

    // low lane fields take the written bits and hold otherwise
    a_turbo_wr: assert property (s_cfg_wr_lo |=> turbo_ratio_select == $past(pwdata[ACC_TURBO_BIT])) // R05
        else $error("turbo select did not take written bit");
    a_field_wr: assert property (s_cfg_wr_lo |=> // R06
        oversampling_ratio_field == $past(pwdata[ACC_RATIO_LSB +: ACC_RATIO_W]))
        else $error("ratio field did not take written bits");
    a_lo_hold: assert property (!wr_cfg_lo |=> // R05 R06
        $stable(turbo_ratio_select) && $stable(oversampling_ratio_field))
        else $error("low lane field changed without a write");
    a_turbo_hold: assert property (turbo_ff |=> osr_value == ACC_OSR_TURBO) // R05
        else $error("ratio is not 64 while turbo is set");

    // decimators restart on the pulse, so it must mark exactly the cycles in which the ratio moves
    a_update_pulse: assert property (osr_update == $changed(osr_value))
        else $error("change pulse does not match a ratio change");

    // first cycle of a transfer on the bus
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_answer_ok;
        pready && !pslverr;
    endsequence

    // unmapped places are refused in the single access cycle, mapped ones never
    a_err_unmapped: assert property (s_setup ##0 (paddr != ACC_CFG_ADDR && paddr != ACC_STAT_ADDR) |=>
        pready && pslverr)
        else $error("unmapped access was not refused");
    a_err_mapped: assert property (s_setup ##0 (paddr == ACC_CFG_ADDR || paddr == ACC_STAT_ADDR) |=> s_answer_ok)
        else $error("mapped access was refused");
    // an error stands for its one access cycle only
    a_err_short: assert property (pslverr |=> !pslverr)
        else $error("error flag lingered past its access");

    // a read shows what was stored at its setup cycle
    a_cfg_readback: assert property (s_setup ##0 (!pwrite && paddr == ACC_CFG_ADDR) |=> // R01 R02 R03 R05 R06
        prdata[ACC_CH0_BIT +: ACC_NUM_CHAN] == $past({chan_two_enable, chan_one_enable, chan_zero_enable})
        && prdata[ACC_TURBO_BIT] == $past(turbo_ratio_select)
        && prdata[ACC_RATIO_LSB +: ACC_RATIO_W] == $past(oversampling_ratio_field))
        else $error("config read does not show the stored fields");
    a_stat_readback: assert property (s_setup ##0 (!pwrite && paddr == ACC_STAT_ADDR) |=>
        prdata[ACC_STAT_OSR_LSB +: ACC_OSR_W] == $past(osr_value) && prdata[ACC_STAT_TURBO_BIT] == $past(turbo_ff))
        else $error("status read does not show the effective ratio");

    // sticky flag: a clear write or reset drops it, and nothing else does
    sequence s_stat_clr;
        psel && penable && pready_ff && pwrite && (paddr == ACC_STAT_ADDR)
        && pstrb[ACC_LANE_ST] && pwdata[ACC_STAT_RSVW_BIT];
    endsequence
    a_rsv_flag_clr: assert property (s_stat_clr |=> !rsvw_ff)
        else $error("reserved-bit flag not cleared");
    a_rsv_flag_hold: assert property (rsvw_ff && !wr_stat_clr |=> rsvw_ff) // R04
        else $error("reserved-bit flag dropped without a clear");
endmodule
`default_nettype wire

// ---- logic/acc_ratio_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_ratio_decode
    import acc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic turbo, // turbo ratio select
    input wire logic [ACC_RATIO_W-1:0] field, // oversampling ratio field
    output logic [ACC_OSR_W-1:0] ratio, // registered effective ratio
    output logic update // one-cycle pulse when ratio changes
);
    logic [ACC_OSR_W-1:0] ratio_ff; // effective ratio
    logic [ACC_OSR_W-1:0] nxt_ratio; // next effective ratio
    logic update_ff; // change pulse
    logic nxt_update; // next change pulse

    // turbo overrides the field; otherwise each code doubles from 128
    always_comb begin
        if (turbo) begin
            nxt_ratio = ACC_OSR_TURBO; // R05
        end else begin
            nxt_ratio = ACC_OSR_W'(ACC_OSR_BASE << field); // R06 R07 R08
        end
        nxt_update = (nxt_ratio != ratio_ff); // decimators restart on this
    end

    // register the decode so the filter sees a glitch-free value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ratio_ff <= ACC_OSR_RST;
            update_ff <= 1'h0;
        end else begin
            ratio_ff <= nxt_ratio;
            update_ff <= nxt_update;
        end
    end

    assign ratio = ratio_ff;
    assign update = update_ff;
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// one comparison: counted, and reported at once on a mismatch
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
    import acc_pkg::*;
;
    logic clk_sys = 1'b0; // 40 MHz system clock
    logic rst = 1'b1; // async reset, active high
    logic [ACC_ADDR_W-1:0] paddr = '0; // apb address
    logic psel = 1'b0; // apb select
    logic penable = 1'b0; // apb enable
    logic pwrite = 1'b0; // apb direction
    logic [ACC_DATA_W-1:0] pwdata = '0; // apb write data
    logic [3:0] pstrb = 4'hF; // apb byte strobes
    logic [ACC_DATA_W-1:0] prdata; // apb read data
    logic pready; // apb ready
    logic pslverr; // apb error
    logic chan_zero_enable; // channel zero enable
    logic chan_one_enable; // channel one enable
    logic chan_two_enable; // channel two enable
    logic turbo_ratio_select; // turbo ratio selected
    logic [ACC_RATIO_W-1:0] oversampling_ratio_field; // raw ratio field
    logic [ACC_OSR_W-1:0] osr_value; // effective ratio
    logic osr_update; // ratio change pulse
    int n_mismatch = 0; // mismatches seen
    int n_checks = 0; // comparisons made
    int cycles = 0; // timeout counter
    logic [ACC_DATA_W-1:0] rd; // last read data
    logic er; // last read error flag
    // device under test
    acc_osr_config acc_osr_config_inst (
        .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_zero_enable(chan_zero_enable), .chan_one_enable(chan_one_enable),
        .chan_two_enable(chan_two_enable), .turbo_ratio_select(turbo_ratio_select),
        .oversampling_ratio_field(oversampling_ratio_field), .osr_value(osr_value),
        .osr_update(osr_update)
    );
    // free-running clock, 25 ns period
    always #12.5 clk_sys = ~clk_sys;
    // hang guard: whole run is under two hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // counts, then the verdict
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one apb transfer; the answer is waited for, never assumed
    task automatic apb_xfer(input logic [ACC_ADDR_W-1:0] a, input logic w, input logic [ACC_DATA_W-1:0] d,
                            input logic [3:0] s);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        // read data and error are taken at the ready edge only
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // expected config word from the field layout
    function automatic logic [ACC_DATA_W-1:0] cfg(input logic [2:0] ch, input logic tb, input logic [2:0] c);
        return {16'h0000, 5'h00, ch, 2'h0, tb, c, 2'h0}; // reserved 7:6 always written zero
    endfunction
    // effective ratio expected from turbo and code, listed code by code
    function automatic logic [ACC_OSR_W-1:0] osr(input logic tb, input logic [2:0] c);
        logic [ACC_OSR_W-1:0] r;
        case (c)
            3'h0: r = 15'h0080;
            3'h1: r = 15'h0100;
            3'h2: r = 15'h0200;
            3'h3: r = 15'h0400;
            3'h4: r = 15'h0800;
            3'h5: r = 15'h1000;
            3'h6: r = 15'h2000;
            default: r = 15'h4000; // code 111
        endcase
        return tb ? 15'h0040 : r;
    endfunction
    // port levels against the expected settings
    task automatic chk_ports(input logic [2:0] ch, input logic tb, input logic [2:0] c);
        `CHK({chan_two_enable, chan_one_enable, chan_zero_enable}, ch)
        `CHK(turbo_ratio_select, tb)
        `CHK(oversampling_ratio_field, c)
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        // reset defaults at the ports and in the register
        @(posedge clk_sys);
        #1;
        chk_ports(3'h7, 1'b0, 3'h3);
        `CHK(osr_value, 15'h0400)
        `CHK({pready, pslverr, prdata}, 34'h0)
        apb_xfer(ACC_CFG_ADDR, 1'b0, '0, 4'hF);
        `CHK(rd, 32'h0000070C)
        `CHK(er, 1'b0)
        $display("test reset_values done");
        // every combination of channel enables, read back each time
        for (int i = 0; i < 8; i++) begin
            apb_xfer(ACC_CFG_ADDR, 1'b1, cfg(3'(i), 1'b0, 3'h3), 4'hF);
            @(posedge clk_sys);
            #1;
            chk_ports(3'(i), 1'b0, 3'h3);
            apb_xfer(ACC_CFG_ADDR, 1'b0, '0, 4'hF);
            `CHK(rd, cfg(3'(i), 1'b0, 3'h3))
        end
        $display("test channel_enables done");
        // every ratio code, with its change pulse one cycle later
        for (int c = 0; c < 8; c++) begin
            apb_xfer(ACC_CFG_ADDR, 1'b1, cfg(3'h7, 1'b0, 3'(c)), 4'hF);
            @(posedge clk_sys);
            #1;
            `CHK(osr_value, osr(1'b0, 3'(c)))
            `CHK(osr_update, 1'b1)
            @(posedge clk_sys);
            #1;
            `CHK(osr_update, 1'b0)
        end
        $display("test ratio_codes done");
        // turbo overrides the field, then the field returns
        apb_xfer(ACC_CFG_ADDR, 1'b1, cfg(3'h7, 1'b1, 3'h6), 4'hF);
        repeat (2) @(posedge clk_sys);
        #1;
        chk_ports(3'h7, 1'b1, 3'h6);
        `CHK(osr_value, 15'h0040)
        apb_xfer(ACC_CFG_ADDR, 1'b1, cfg(3'h7, 1'b0, 3'h6), 4'hF);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(osr_value, 15'h2000)
        $display("test turbo done");
        // low lane only: channel enables must keep their value
        apb_xfer(ACC_CFG_ADDR, 1'b1, 32'h00000000, 4'h1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk_ports(3'h7, 1'b0, 3'h0);
        `CHK(osr_value, 15'h0080)
        // status mirrors the effective ratio
        apb_xfer(ACC_STAT_ADDR, 1'b0, '0, 4'hF);
        `CHK(rd, 32'h00000080)
        `CHK(er, 1'b0)
        // clearing the sticky flag is a status write that is never refused
        apb_xfer(ACC_STAT_ADDR, 1'b1, 32'h00010000, 4'h4);
        `CHK(er, 1'b0)
        apb_xfer(ACC_STAT_ADDR, 1'b0, '0, 4'hF);
        `CHK(rd, 32'h00000080)
        // unmapped place: refused, and config untouched
        apb_xfer(12'h100, 1'b1, 32'h00000000, 4'hF);
        apb_xfer(12'h100, 1'b0, '0, 4'hF);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h00000000)
        apb_xfer(ACC_CFG_ADDR, 1'b0, '0, 4'hF);
        `CHK(rd, cfg(3'h7, 1'b0, 3'h0))
        $display("test strobes_and_unmapped done");
        // mid-run reset returns the defaults
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk_ports(3'h7, 1'b0, 3'h3);
        `CHK(osr_value, 15'h0400)
        `CHK(osr_update, 1'b0)
        apb_xfer(ACC_CFG_ADDR, 1'b0, '0, 4'hF);
        `CHK(rd, 32'h0000070C)
        $display("test second_reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
